// ---- rtl/main_clock_rc_pll_control.sv ----
// main clock control: rc trim, pll model, slow mode, clock out, calibration store
// assumes option straps are stable from reset release; clocks are modelled as
// one-cycle enable pulses on the 20 MHz system clock
`timescale 1ns/1ns
module main_clock_rc_pll_control
   import clk_ctrl_pkg::*;
#(
   parameter logic [7:0] FACTORY_5V = 8'h80, // arbitrary factory value
   parameter logic [7:0] FACTORY_3V = 8'h80 // arbitrary factory value
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   input wire logic [clk_ctrl_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic OPT_RC_EN_I,
   input wire logic OPT_PLL_EN_I,
   input wire logic OPT_PLL_X8_I,
   input wire logic OPT_TMR_MUL_EN_I,
   input wire logic OPT_EXT_HALF_I,
   input wire logic EXT_TICK_I,
   input wire logic HALT_I,
   input wire logic READOUT_PROT_I,
   input wire logic GPIO_OUT_I,
   input wire logic GPIO_OE_I,
   output logic MAIN_OSC_TICK_O,
   output logic CPU_TICK_O,
   output logic TIMER_CLK_EN_O,
   output logic PLL_LOCKED_O,
   output logic [7:0] RC_TRIM_O,
   output logic CLKOUT_PIN_O,
   output logic CLKOUT_PIN_OE_O,
   output logic IRQ_O
);
   clk_div_if dif();

   logic strap_done_reg;
   logic opt_rc_reg, opt_pll_reg, opt_x8_reg, opt_tmr_reg, opt_half_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] trim_reg;
   logic [7:0] cal5_reg;
   logic [7:0] cal3_reg;
   logic prot_seen_reg;
   logic [IRQ_W-1:0] irq_sts_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_sts_next;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   pll_state_t pll_state;
   pll_state_t pll_state_next;
   logic [CNT_W-1:0] pll_cnt_reg;
   logic [CNT_W-1:0] pll_cnt_next;
   logic [5:0] acc_reg;
   logic ext_half_reg;
   logic osc_tick_reg;
   logic mco_clk_reg;
   logic pin_out_reg;
   logic pin_oe_reg;
   logic tmr_en_reg;
   logic locked_reg;
   logic tmr_fault_seen_reg;

   // bus decode
   wire req = AVS_READ_I || AVS_WRITE_I;
   wire wr_fire = AVS_WRITE_I && ack_reg && AVS_BYTEENABLE_I[0];
   wire sel_ctrl = AVS_ADDRESS_I == OFS_CTRL;
   wire sel_trim = AVS_ADDRESS_I == OFS_TRIM;
   wire sel_stat = AVS_ADDRESS_I == OFS_STATUS;
   wire sel_ists = AVS_ADDRESS_I == OFS_IRQ_STS;
   wire sel_imsk = AVS_ADDRESS_I == OFS_IRQ_MASK;
   wire sel_c5 = AVS_ADDRESS_I == OFS_CAL5_A || AVS_ADDRESS_I == OFS_CAL5_B;
   wire sel_c3 = AVS_ADDRESS_I == OFS_CAL3_A || AVS_ADDRESS_I == OFS_CAL3_B;
   wire [7:0] wbyte = AVS_WRITEDATA_I[7:0];
   wire [7:0] status_val = {4'h0, tmr_en_reg, prot_seen_reg,
      pll_state != PLL_OFF, locked_reg};
   wire [7:0] rd_byte = sel_ctrl ? ctrl_reg : sel_trim ? trim_reg : sel_stat ? status_val :
      sel_ists ? {5'h00, irq_sts_reg} : sel_imsk ? {5'h00, irq_mask_reg} :
      sel_c5 ? cal5_reg : sel_c3 ? cal3_reg : 8'h00;
   assign rdata_next = (AVS_READ_I && !ack_reg) ? {24'h000000, rd_byte} : rdata_reg;
   assign AVS_WAITREQUEST_O = req && !ack_reg;
   assign AVS_READDATA_O = rdata_reg;

   // clock source selection
   wire pll_on = strap_done_reg && opt_pll_reg;
   wire pll_run = pll_state == PLL_LOCKING || pll_state == PLL_LOCKED;
   wire [5:0] inc = !opt_pll_reg ? INC_RC : opt_x8_reg ? INC_X8 : INC_X4;
   wire [5:0] acc_sum = acc_reg + inc;
   wire nco_tick = acc_sum >= NCO_MOD;
   wire [5:0] acc_next = nco_tick ? acc_sum - NCO_MOD : acc_sum;
   wire ext_tick = EXT_TICK_I && (!opt_half_reg || ext_half_reg);
   wire osc_tick = !strap_done_reg || HALT_I ? 1'b0 :
      opt_pll_reg ? (pll_run && nco_tick) :
      opt_rc_reg ? nco_tick :
      ext_tick;
   wire halt_restart = HALT_I || !pll_on;

   // 8 MHz sources for the timer multiplier
   wire src_rc_x8 = opt_rc_reg && opt_pll_reg && opt_x8_reg;
   wire src_ext16 = !opt_rc_reg && !opt_pll_reg && opt_half_reg;
   wire src_ext2 = !opt_rc_reg && opt_pll_reg && opt_x8_reg && opt_half_reg;
   wire tmr_src_ok = src_rc_x8 || src_ext16 || src_ext2;
   wire tmr_ok = strap_done_reg && opt_tmr_reg && tmr_src_ok
      && (!opt_pll_reg || pll_run);
   wire tmr_fault = strap_done_reg && opt_tmr_reg && !tmr_src_ok;

   // pll startup and lock sequencing
   always_comb begin
      pll_state_next = pll_state;
      pll_cnt_next = pll_cnt_reg;
      case (pll_state)
         PLL_OFF: begin
            if (!halt_restart) begin
               pll_state_next = PLL_START;
               pll_cnt_next = CNT_W'(STARTUP_CYC - 1);
            end
         end
         PLL_START: begin
            if (pll_cnt_reg == '0) begin
               pll_state_next = PLL_LOCKING;
               pll_cnt_next = CNT_W'(LOCK_CYC - 1);
            end else begin
               pll_cnt_next = pll_cnt_reg - 1'b1;
            end
         end
         PLL_LOCKING: begin
            if (pll_cnt_reg == '0) begin
               pll_state_next = PLL_LOCKED;
            end else begin
               pll_cnt_next = pll_cnt_reg - 1'b1;
            end
         end
         PLL_LOCKED: pll_state_next = pll_state;
         default: pll_state_next = PLL_OFF;
      endcase
      if (halt_restart) begin
         pll_state_next = PLL_OFF;
      end
   end

   // interrupt events; a new event wins over a same-cycle clear
   wire lock_ev = pll_state == PLL_LOCKING && pll_state_next == PLL_LOCKED;
   wire erase_ev = prot_seen_reg && !READOUT_PROT_I;
   wire fault_ev = tmr_fault && !tmr_fault_seen_reg;
   wire [IRQ_W-1:0] irq_ev = {fault_ev, erase_ev, lock_ev};
   wire [IRQ_W-1:0] irq_clr = (wr_fire && sel_ists) ? wbyte[IRQ_W-1:0] : IRQ_RST;
   assign irq_sts_next = (irq_sts_reg & ~irq_clr) | irq_ev;
   assign IRQ_O = |(irq_sts_reg & irq_mask_reg);

   assign dif.tick_in = osc_tick_reg;
   assign dif.slow_sel = ctrl_reg[BIT_SMS];

   slow_mode_divider i_slow_mode_divider (
      .SYS_CLK_I(SYS_CLK_I),
      .RST_N_I(RST_N_I),
      .dv(dif)
   );

   assign CPU_TICK_O = dif.cpu_tick;
   assign MAIN_OSC_TICK_O = osc_tick_reg;
   assign TIMER_CLK_EN_O = tmr_en_reg;
   assign PLL_LOCKED_O = locked_reg;
   assign RC_TRIM_O = trim_reg;
   assign CLKOUT_PIN_O = pin_out_reg;
   assign CLKOUT_PIN_OE_O = pin_oe_reg;

   // option straps caught on the first edge after reset release
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         strap_done_reg <= 1'b0;
         {opt_rc_reg, opt_pll_reg, opt_x8_reg, opt_tmr_reg, opt_half_reg} <= 5'h00;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         opt_rc_reg <= OPT_RC_EN_I;
         opt_pll_reg <= OPT_PLL_EN_I;
         opt_x8_reg <= OPT_PLL_X8_I;
         opt_tmr_reg <= OPT_TMR_MUL_EN_I;
         opt_half_reg <= OPT_EXT_HALF_I;
      end
   end

   // software registers
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         ctrl_reg <= CTRL_RST;
         trim_reg <= TRIM_RST;
         irq_mask_reg <= IRQ_RST;
         irq_sts_reg <= IRQ_RST;
      end else begin
         ack_reg <= req && !ack_reg;
         rdata_reg <= rdata_next;
         irq_sts_reg <= irq_sts_next;
         if (wr_fire && sel_ctrl) begin
            ctrl_reg <= wbyte & CTRL_WMASK;
         end
         if (wr_fire && sel_trim) begin
            trim_reg <= wbyte;
         end
         if (wr_fire && sel_imsk) begin
            irq_mask_reg <= wbyte[IRQ_W-1:0];
         end
      end
   end

   // calibration store; reset reloads the factory bytes, since the
   // nonvolatile array itself lies outside this block
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cal5_reg <= FACTORY_5V;
         cal3_reg <= FACTORY_3V;
         prot_seen_reg <= 1'b0;
      end else begin
         prot_seen_reg <= READOUT_PROT_I;
         if (erase_ev) begin
            cal5_reg <= CAL_ERASED;
            cal3_reg <= CAL_ERASED;
         end
      end
   end

   // clock path
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pll_state <= PLL_OFF;
         pll_cnt_reg <= '0;
         acc_reg <= 6'h00;
         ext_half_reg <= 1'b0;
         osc_tick_reg <= 1'b0;
         mco_clk_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
         tmr_en_reg <= 1'b0;
         locked_reg <= 1'b0;
         tmr_fault_seen_reg <= 1'b0;
      end else begin
         pll_state <= pll_state_next;
         pll_cnt_reg <= pll_cnt_next;
         acc_reg <= acc_next;
         ext_half_reg <= EXT_TICK_I ? !ext_half_reg : ext_half_reg;
         osc_tick_reg <= osc_tick;
         mco_clk_reg <= osc_tick ? !mco_clk_reg : mco_clk_reg;
         pin_out_reg <= ctrl_reg[BIT_MCO] ? mco_clk_reg : GPIO_OUT_I;
         pin_oe_reg <= ctrl_reg[BIT_MCO] || GPIO_OE_I;
         tmr_en_reg <= tmr_ok;
         locked_reg <= pll_state_next == PLL_LOCKED;
         tmr_fault_seen_reg <= tmr_fault;
      end
   end

   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);

   a_trim_default: assert property ($rose(strap_done_reg) |-> trim_reg == TRIM_RST)
      else $error("trim register not all ones after reset");
   a_cal_mirror: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
      && AVS_ADDRESS_I == OFS_CAL5_B |-> AVS_READDATA_O[7:0] == cal5_reg)
      else $error("5 V calibration mirror mismatch");
   a_cal_erase: assert property (prot_seen_reg && !READOUT_PROT_I
      |=> cal5_reg == CAL_ERASED && cal3_reg == CAL_ERASED)
      else $error("calibration bytes survived protection removal");
   a_pll_withhold: assert property (pll_on && !pll_run |=> !MAIN_OSC_TICK_O)
      else $error("pll clock before startup delay");
   a_lock_flag: assert property (lock_ev |=> PLL_LOCKED_O && irq_sts_reg[IRQ_LOCK])
      else $error("lock flag missing after lock");
   a_rc_direct: assert property (strap_done_reg && opt_rc_reg && !opt_pll_reg
      && !HALT_I && nco_tick |=> MAIN_OSC_TICK_O)
      else $error("rc tick not passed to main clock");
   a_ext_direct: assert property (strap_done_reg && !opt_rc_reg && !opt_pll_reg
      && !opt_half_reg && !HALT_I && EXT_TICK_I |=> MAIN_OSC_TICK_O)
      else $error("external tick not passed to main clock");
   a_x8_rate: assert property (pll_run && opt_x8_reg && !HALT_I && pll_on
      |-> inc == INC_X8)
      else $error("pll factor not eight");
   a_tmr_source: assert property (TIMER_CLK_EN_O |-> $past(tmr_src_ok) && opt_tmr_reg)
      else $error("timer multiplier enabled without 8 MHz input");
   a_reserved_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && sel_ctrl
      |-> AVS_READDATA_O[7:2] == 6'h00)
      else $error("reserved control bits read non-zero");
   a_mco_drive: assert property (ctrl_reg[BIT_MCO] |=> CLKOUT_PIN_OE_O)
      else $error("clock output pin not driven");
   a_set_wins: assert property (lock_ev && wr_fire && sel_ists && wbyte[IRQ_LOCK]
      |=> irq_sts_reg[IRQ_LOCK])
      else $error("lock event lost to clear");

   c_locked: cover property (lock_ev);
   c_erase: cover property (erase_ev);
   c_mco_on: cover property (ctrl_reg[BIT_MCO] && MAIN_OSC_TICK_O);
   c_irq: cover property ($rose(IRQ_O));
endmodule // main_clock_rc_pll_control

// ---- rtl/clk_ctrl_pkg.sv ----
// constants and types of the main clock control block
// assumes a 20 MHz system clock and word-aligned Avalon-MM register access
package clk_ctrl_pkg;
   localparam int CLK_MHZ = 20;
   localparam int T_STARTUP_NS = 100000;
   localparam int STARTUP_CYC = (T_STARTUP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_LOCK_NS = 200000;
   localparam int LOCK_CYC = (T_LOCK_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 12;
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_TRIM = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 6'h0c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_CAL5_A = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_CAL5_B = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_CAL3_A = 6'h1c;
   localparam logic [ADDR_W-1:0] OFS_CAL3_B = 6'h20;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'h03;
   localparam logic [7:0] TRIM_RST = 8'hff;
   localparam logic [7:0] CAL_ERASED = 8'hff;
   localparam int BIT_SMS = 0;
   localparam int BIT_MCO = 1;
   localparam int IRQ_W = 3;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_ERASE = 1;
   localparam int IRQ_TMR_FAULT = 2;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
   localparam logic [5:0] NCO_MOD = 6'h14;
   localparam logic [5:0] INC_RC = 6'h01;
   localparam logic [5:0] INC_X4 = 6'h04;
   localparam logic [5:0] INC_X8 = 6'h08;
   localparam logic [4:0] SLOW_LAST = 5'h1f;
   typedef enum {PLL_OFF, PLL_START, PLL_LOCKING, PLL_LOCKED} pll_state_t;
endpackage

// ---- rtl/clk_div_if.sv ----
// signals between the clock control core and its slow-mode divider
// assumes both ends run on the same system clock
`timescale 1ns/1ns
interface clk_div_if;
   logic tick_in;
   logic slow_sel;
   logic cpu_tick;
   logic slow_act;
   modport ctrl(output tick_in, output slow_sel, input cpu_tick, input slow_act);
   modport div(input tick_in, input slow_sel, output cpu_tick, output slow_act);
endinterface

// ---- rtl/slow_mode_divider.sv ----
// cpu tick generator: main oscillator tick, or one in 32 in slow mode
// assumes tick_in is a one-cycle enable pulse on the system clock
`timescale 1ns/1ns
module slow_mode_divider
   import clk_ctrl_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   clk_div_if.div dv
);
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic slow_reg;
   logic slow_next;
   logic tick_reg;
   wire period_end = !slow_reg || (cnt_reg == SLOW_LAST);

   // mode only changes on a tick that ends a period (any tick in normal mode, the 32nd in slow mode), so no short pulse
   assign slow_next = (dv.tick_in && period_end) ? dv.slow_sel : slow_reg;
   assign cnt_next = !dv.tick_in ? cnt_reg : period_end ? 5'h00 : cnt_reg + 5'h01;
   assign dv.cpu_tick = tick_reg;
   assign dv.slow_act = slow_reg;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cnt_reg <= 5'h00;
         slow_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         slow_reg <= slow_next;
         tick_reg <= dv.tick_in && period_end;
      end
   end

   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);

   a_slow_gap: assert property (slow_reg && dv.tick_in && cnt_reg != SLOW_LAST |=> !tick_reg)
      else $error("cpu tick inside a slow period");
   a_switch_edge: assert property ($changed(slow_reg) |->
      $past(cnt_reg) == SLOW_LAST || !$past(slow_reg))
      else $error("slow mode switched mid period");
   c_slow_tick: cover property (slow_reg && tick_reg);
endmodule // slow_mode_divider

// ---- test/main_clock_rc_pll_control_tb.sv ----
// self-checking bench for the main clock control block
// assumes the package, divider interface and divider are compiled first; one 20 MHz clock
`timescale 1ns/1ns
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module main_clock_rc_pll_control_tb;
   import clk_ctrl_pkg::*;
   localparam logic [7:0] F5 = 8'h5a; // arbitrary factory value
   localparam logic [7:0] F3 = 8'hc3; // arbitrary factory value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [3:0] be = 4'hf;
   logic [31:0] wdata = '0;
   logic [31:0] rdata;
   logic waitreq;
   logic [4:0] opt = 5'h00;
   logic ext_tick = 1'b0;
   logic halt = 1'b0;
   logic prot = 1'b0;
   logic gpio_out = 1'b0;
   logic gpio_oe = 1'b0;
   logic main_tick;
   logic cpu_tick;
   logic tmr_en;
   logic locked;
   logic [7:0] rc_trim;
   logic pin;
   logic pin_oe;
   logic irq;
   logic [15:0] seed = 16'h7fc9;
   logic [31:0] exp_q [$];
   logic [31:0] e_rd;
   logic [ADDR_W-1:0] cal_a [4] = '{OFS_CAL5_A, OFS_CAL5_B, OFS_CAL3_A, OFS_CAL3_B};
   logic [7:0] cal_v [4] = '{F5, F5, F3, F3};
   int errors = 0;
   int checks = 0;

   main_clock_rc_pll_control #(.FACTORY_5V(F5), .FACTORY_3V(F3)) i_main_clock_rc_pll_control (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdata),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .OPT_RC_EN_I(opt[0]),
      .OPT_PLL_EN_I(opt[1]), .OPT_PLL_X8_I(opt[2]), .OPT_TMR_MUL_EN_I(opt[3]),
      .OPT_EXT_HALF_I(opt[4]), .EXT_TICK_I(ext_tick), .HALT_I(halt), .READOUT_PROT_I(prot),
      .GPIO_OUT_I(gpio_out), .GPIO_OE_I(gpio_oe), .MAIN_OSC_TICK_O(main_tick),
      .CPU_TICK_O(cpu_tick), .TIMER_CLK_EN_O(tmr_en), .PLL_LOCKED_O(locked),
      .RC_TRIM_O(rc_trim), .CLKOUT_PIN_O(pin), .CLKOUT_PIN_OE_O(pin_oe), .IRQ_O(irq));

   always #25 clk = ~clk;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // random external clock pulses reach the design in every mode
   always @(posedge clk) begin
      seed <= lfsr(seed);
      ext_tick <= seed[0] & seed[3];
   end

   // read results are compared in the order the driver noted them
   always @(posedge clk) begin
      if (rd && waitreq === 1'b0 && exp_q.size() > 0) begin
         e_rd = exp_q.pop_front();
         `CMP(rdata, e_rd)
      end
   end

   task automatic close_out();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one bus cycle; entered right after a rising edge, returns one idle edge after commit
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      input logic [7:0] e);
      int n;
      n = 0;
      addr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= {24'h0, d};
      if (!w)
         exp_q.push_back({24'h0, e});
      @(posedge clk);
      while (waitreq !== 1'b0 && n < 16) begin
         @(posedge clk);
         n++;
      end
      if (waitreq !== 1'b0) begin
         errors++;
         close_out();
      end
      rd <= 1'b0;
      wr <= 1'b0;
      // idle edge so a following call never re-raises a strobe in the same step
      @(posedge clk);
   endtask

   task automatic rst(input logic [4:0] o);
      rst_n <= 1'b0;
      opt <= o;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask

   // counts main ticks, cpu ticks and pin toggles; optionally follows the external clock
   task automatic run(input int n, input bit ext, output int m, output int c, output int t);
      logic ed;
      logic pd;
      m = 0;
      c = 0;
      t = 0;
      ed = ext_tick;
      pd = pin;
      repeat (n) begin
         @(posedge clk);
         if (ext) `CMP(main_tick, ed)
         m += main_tick;
         c += cpu_tick;
         t += (pin !== pd);
         pd = pin;
         ed = ext_tick;
      end
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      close_out();
   end

   initial begin
      int m, c, t, n;
      logic [7:0] v;
      rst(5'h01);
      bus(0, OFS_CTRL, 0, CTRL_RST);
      bus(0, OFS_TRIM, 0, TRIM_RST);
      `CMP(rc_trim, TRIM_RST)
      foreach (cal_a[i]) bus(0, cal_a[i], 0, cal_v[i]);
      for (int k = 7; k >= 0; k--) begin
         bus(1, OFS_TRIM, 8'h01 << k, 0);
         bus(0, OFS_TRIM, 0, 8'h01 << k);
      end
      v = seed[7:0];
      bus(1, OFS_TRIM, v, 0);
      repeat (2) @(posedge clk);
      `CMP(rc_trim, v)
      // writes with byte 0 disabled and to an unused word must leave everything alone
      be <= 4'he;
      bus(1, OFS_TRIM, ~v, 0);
      be <= 4'hf;
      bus(0, OFS_TRIM, 0, v);
      bus(1, 6'h3c, 8'h55, 0);
      bus(0, 6'h3c, 0, 8'h00);
      bus(1, OFS_CTRL, 8'hfc, 0);
      bus(0, OFS_CTRL, 0, 8'h00);
      gpio_out <= 1'b1;
      gpio_oe <= 1'b1;
      run(200, 0, m, c, t);
      `CMP(m, 10)
      `CMP(c, 10)
      `CMP(pin, 1'b1)
      `CMP(pin_oe, 1'b1)
      gpio_out <= 1'b0;
      gpio_oe <= 1'b0;
      run(4, 0, m, c, t);
      `CMP(pin_oe, 1'b0)
      bus(1, OFS_CTRL, 8'h03, 0);
      run(1400, 0, m, c, t);
      run(6400, 0, m, c, t);
      `CMP(c, 10)
      `CMP(t, 320)
      `CMP(pin_oe, 1'b1)
      bus(1, OFS_CTRL, 8'h00, 0);
      run(1400, 0, m, c, t);
      run(200, 0, m, c, t);
      `CMP(c, 10)
      rst(5'h01);
      bus(0, OFS_TRIM, 0, TRIM_RST);
      bus(0, OFS_CTRL, 0, CTRL_RST);
      rst(5'h00);
      // straps only steer the source one edge after they are captured
      @(posedge clk);
      run(300, 1, m, c, t);
      rst(5'h18);
      repeat (2) @(posedge clk);
      `CMP(tmr_en, 1'b1)
      for (int x = 0; x < 2; x++) begin
         rst({2'b01, x[0], 2'b11});
         run(1900, 0, m, c, t);
         `CMP(m, 0)
         n = 0;
         while (locked !== 1'b1 && n < 8000) begin
            @(posedge clk);
            n++;
         end
         `CMP(locked, 1'b1)
         if (locked !== 1'b1)
            close_out();
         run(200, 0, m, c, t);
         `CMP(m, 40 << x)
         `CMP(tmr_en, x[0])
         bus(0, OFS_STATUS, 0, {4'h0, x[0], 3'h3});
         bus(0, OFS_IRQ_STS, 0, {5'h0, ~x[0], 2'h1});
         `CMP(irq, 1'b0)
         bus(1, OFS_IRQ_MASK, 8'h07, 0);
         @(posedge clk);
         `CMP(irq, 1'b1)
         bus(1, OFS_IRQ_STS, 8'h01, 0);
         bus(0, OFS_IRQ_STS, 0, {5'h0, ~x[0], 2'h0});
         @(posedge clk);
         `CMP(irq, ~x[0])
         halt <= 1'b1;
         run(10, 0, m, c, t);
         halt <= 1'b0;
         run(1900, 0, m, c, t);
         `CMP(m, 0)
      end
      // protection set then cleared wipes both stored calibration bytes
      prot <= 1'b1;
      run(5, 0, m, c, t);
      prot <= 1'b0;
      run(5, 0, m, c, t);
      foreach (cal_a[i]) bus(0, cal_a[i], 0, CAL_ERASED);
      bus(0, OFS_IRQ_STS, 0, 8'h02);
      @(posedge clk);
      `CMP(irq, 1'b1)
      repeat (2) @(posedge clk);
      `CMP(exp_q.size(), 0)
      close_out();
   end
endmodule // main_clock_rc_pll_control_tb
